// ==== common/qsp_defines.vh ====
// constants shared by the sram user command port and its write queue
`ifndef QSP_DEFINES_VH
`define QSP_DEFINES_VH

// clock rate of core_clk, in megahertz
`define QSP_CLK_MHZ 100

// time spent in read calibration after reset, in microseconds
`define QSP_CAL_TIME_US 10

// calibration time as a count of core_clk cycles (10 us at 100 MHz),
// sized to the calibration counter so the default drops no bits
`define QSP_CAL_CYCLES 16'h03e8

// width of the calibration cycle counter
`define QSP_CAL_CNT_W 16

// memory address width (one word address per request)
`define QSP_ADDR_W 22

// data bits of the memory per beat
`define QSP_MEM_DW 18

// data bits covered by one byte-write enable
`define QSP_BYTE_BITS 9

// beats per request: 2 selects burst-of-two, 4 burst-of-four
`define QSP_BURST_LENGTH 2

// user data bus width: a whole burst per request
`define QSP_DATA_W (`QSP_MEM_DW * `QSP_BURST_LENGTH)

// byte-write enable width: one enable per byte per beat
`define QSP_BW_W ((`QSP_MEM_DW / `QSP_BYTE_BITS) * `QSP_BURST_LENGTH)

// width of one queued write: address, data, byte enables
`define QSP_WQ_W (`QSP_ADDR_W + `QSP_DATA_W + `QSP_BW_W)

// write queue depth and its pointer width
`define QSP_WQ_DEPTH 8
`define QSP_WQ_AW 3

// number of user ports; the second is live in burst-of-two only
`define QSP_NUM_PORTS 2

// width of the reserved debug bus
`define QSP_DBG_W 8

`endif

// ==== rtl/qsp_fifo.v ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns

module qsp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
)
(
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	// depth must be a power of two so that the pointers wrap by themselves
	localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
	localparam [AW:0] EMPTY_COUNT = {(AW+1){1'b0}};

	// storage array, no reset needed: count guards stale words
	reg [WIDTH-1:0] store_r [0:DEPTH-1];
	// write and read pointers
	reg [AW-1:0] wptr_r;
	reg [AW-1:0] rptr_r;
	// number of words held
	reg [AW:0] count_r;

	// handshakes that really move a word
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// honest full and empty from the count
	assign in_ready = (count_r != FULL_COUNT);
	assign out_valid = (count_r != EMPTY_COUNT);
	// head word straight from the array flip-flops
	assign out_data = store_r[rptr_r];

	// array write on push only
	always @(posedge clk)
	begin
		if (push)
			store_r[wptr_r] <= in_data;
	end

	// pointer and count upkeep
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wptr_r <= {AW{1'b0}};
			rptr_r <= {AW{1'b0}};
			count_r <= EMPTY_COUNT;
		end
		else
		begin
			// advance the write side
			if (push)
				wptr_r <= wptr_r + 1'b1;
			// advance the read side
			if (pop)
				rptr_r <= rptr_r + 1'b1;
			// push and pop together leave the count alone
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule

// ==== rtl/qsp_user_port.v ====
// user command port of the quad-data-rate sram controller
`timescale 1ns/1ns
`include "qsp_defines.vh"

// Operation
// - requests before calibration done are ignored
// - simultaneous read and write: read goes first
// - reads accepted back to back; writes only while write ready shows room in the 8-deep queue
// - read valid marks unbuffered data, capture immediately
// - data buses carry a whole burst
// - burst-of-two adds an independent second port
// - user clock and synchronized reset are provided
// - asynchronous system reset, differential system clock
// - calibration done rises after read calibration
// - separate read and write strobes, shared address
module qsp_user_port #(
	parameter [`QSP_CAL_CNT_W-1:0] CAL_CYCLES = `QSP_CAL_CYCLES
)
(
	// system clock, taken after the differential pad receiver
	input wire core_clk,
	// asynchronous system reset
	input wire rst,
	// user clock and reset synchronized to it
	output wire user_clk,
	output wire user_rst,
	// high once read calibration is over
	output wire calibration_done,
	// port 0 write side
	input wire write_request_p0,
	input wire [`QSP_ADDR_W-1:0] write_address_p0,
	input wire [`QSP_DATA_W-1:0] write_payload_p0,
	input wire [`QSP_BW_W-1:0] byte_write_enables_n_p0,
	output wire write_ready_p0,
	// port 0 read side
	input wire read_request_p0,
	input wire [`QSP_ADDR_W-1:0] read_address_p0,
	output wire [`QSP_DATA_W-1:0] read_payload_p0,
	output wire read_payload_valid_p0,
	// port 1 write side, live in burst-of-two only
	input wire write_request_p1,
	input wire [`QSP_ADDR_W-1:0] write_address_p1,
	input wire [`QSP_DATA_W-1:0] write_payload_p1,
	input wire [`QSP_BW_W-1:0] byte_write_enables_n_p1,
	output wire write_ready_p1,
	// port 1 read side, live in burst-of-two only
	input wire read_request_p1,
	input wire [`QSP_ADDR_W-1:0] read_address_p1,
	output wire [`QSP_DATA_W-1:0] read_payload_p1,
	output wire read_payload_valid_p1,
	// memory side of port 0, toward the phy
	output wire mem_read_n_p0,
	output wire mem_write_n_p0,
	output wire [`QSP_ADDR_W-1:0] mem_address_p0,
	output wire [`QSP_DATA_W-1:0] mem_write_data_p0,
	output wire [`QSP_BW_W-1:0] mem_byte_write_n_p0,
	input wire [`QSP_DATA_W-1:0] mem_read_data_p0,
	input wire mem_read_data_valid_p0,
	// memory side of port 1, toward the phy
	output wire mem_read_n_p1,
	output wire mem_write_n_p1,
	output wire [`QSP_ADDR_W-1:0] mem_address_p1,
	output wire [`QSP_DATA_W-1:0] mem_write_data_p1,
	output wire [`QSP_BW_W-1:0] mem_byte_write_n_p1,
	input wire [`QSP_DATA_W-1:0] mem_read_data_p1,
	input wire mem_read_data_valid_p1,
	// reserved debug outputs, to be left open
	output wire debug_clk,
	output wire [`QSP_DBG_W-1:0] debug_bus
);

	// shorthand widths
	localparam AW = `QSP_ADDR_W;
	localparam DW = `QSP_DATA_W;
	localparam BW = `QSP_BW_W;
	localparam QW = `QSP_WQ_W;
	localparam NP = `QSP_NUM_PORTS;

	// second port is always built but live only in burst-of-two
	localparam burst_two_mode = (`QSP_BURST_LENGTH == 2);
	localparam burst_four_mode = (`QSP_BURST_LENGTH == 4);

	// calibration counter limits
	localparam [`QSP_CAL_CNT_W-1:0] CAL_ZERO = {`QSP_CAL_CNT_W{1'b0}};
	localparam [`QSP_CAL_CNT_W-1:0] CAL_ONE = {{(`QSP_CAL_CNT_W-1){1'b0}},1'b1};

	// calibration sequencer states
	localparam [1:0] ST_RESET = 2'h0;
	localparam [1:0] ST_CAL = 2'h1;
	localparam [1:0] ST_READY = 2'h2;

	// a request counts only after calibration and on a live port
	function req_take;
		input cal_ok;
		input req;
		input port_live;
		begin
			req_take = cal_ok & req & port_live;
		end
	endfunction

	// reset synchronizer: async assert, release on the second edge
	reg rst_meta_r;
	reg rst_sync_r;
	// calibration state and cycle counter
	reg [1:0] cal_state_r;
	reg [1:0] cal_state_nxt;
	reg [`QSP_CAL_CNT_W-1:0] cal_cnt_r;
	reg [`QSP_CAL_CNT_W-1:0] cal_cnt_nxt;
	reg cal_done_r;

	// the user clock is the system clock itself; no second domain
	assign user_clk = core_clk;
	assign user_rst = rst_sync_r;

	// reset synchronizer, flops take only constants under reset
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= 1'b1;
		end
		else
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= rst_meta_r;
		end
	end

	// next state of the calibration sequencer
	always @*
	begin
		cal_state_nxt = cal_state_r;
		cal_cnt_nxt = cal_cnt_r;
		case (cal_state_r)
			// leave reset and start counting the training time
			ST_RESET:
			begin
				cal_state_nxt = ST_CAL;
				cal_cnt_nxt = CAL_ZERO;
			end
			// training in progress; the phy owns the pins meanwhile
			ST_CAL:
			begin
				if (cal_cnt_r >= CAL_CYCLES - CAL_ONE)
					cal_state_nxt = ST_READY;
				else
					cal_cnt_nxt = cal_cnt_r + CAL_ONE;
			end
			// calibrated; stays here until the next reset
			ST_READY:
			begin
				cal_state_nxt = ST_READY;
			end
			default:
			begin
				cal_state_nxt = ST_RESET;
			end
		endcase
	end

	// calibration registers, cleared by the synchronized reset
	always @(posedge core_clk or posedge rst_sync_r)
	begin
		if (rst_sync_r)
		begin
			cal_state_r <= ST_RESET;
			cal_cnt_r <= CAL_ZERO;
			cal_done_r <= 1'b0;
		end
		else
		begin
			cal_state_r <= cal_state_nxt;
			cal_cnt_r <= cal_cnt_nxt;
			cal_done_r <= (cal_state_nxt == ST_READY);
		end
	end

	// done is forced low while the user reset stands
	assign calibration_done = cal_done_r & ~rst_sync_r;

	// user and memory buses gathered into vectors for the port loop
	wire [NP-1:0] wr_req_v = {write_request_p1, write_request_p0};
	wire [NP-1:0] rd_req_v = {read_request_p1, read_request_p0};
	wire [NP*AW-1:0] wr_addr_v = {write_address_p1, write_address_p0};
	wire [NP*AW-1:0] rd_addr_v = {read_address_p1, read_address_p0};
	wire [NP*DW-1:0] wr_data_v = {write_payload_p1, write_payload_p0};
	wire [NP*BW-1:0] wr_bw_v =
		{byte_write_enables_n_p1, byte_write_enables_n_p0};
	wire [NP*DW-1:0] mem_q_v = {mem_read_data_p1, mem_read_data_p0};
	wire [NP-1:0] mem_qv_v = {mem_read_data_valid_p1, mem_read_data_valid_p0};

	// per-port results, one driver per slice
	wire [NP-1:0] wr_ready_v;
	wire [NP-1:0] rd_valid_v;
	wire [NP*DW-1:0] rd_data_v;
	wire [NP-1:0] mem_rd_n_v;
	wire [NP-1:0] mem_wr_n_v;
	wire [NP*AW-1:0] mem_addr_v;
	wire [NP*DW-1:0] mem_wd_v;
	wire [NP*BW-1:0] mem_bw_v;
	wire [NP-1:0] wq_level_v;

	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1)
		begin : port
			// port 0 always runs; port 1 only in burst-of-two
			wire live = (g == 0) | burst_two_mode;
			// single-cycle pulses, sampled with their sidebands
			wire rd_take = req_take(cal_done_r, rd_req_v[g], live);
			wire wr_want = req_take(cal_done_r, wr_req_v[g], live);
			// write queue signals
			wire wq_in_ready;
			wire wq_out_valid;
			wire [QW-1:0] wq_out;
			// address, burst data and byte enables travel as one word
			wire [QW-1:0] wq_in = {wr_addr_v[g*AW +: AW],
				wr_data_v[g*DW +: DW], wr_bw_v[g*BW +: BW]};
			// a read owns the shared address slot, so writes wait
			wire drain = wq_out_valid & ~rd_take;
			// issue registers toward the memory
			reg rd_n_r;
			reg wr_n_r;
			reg [AW-1:0] addr_r;
			reg [DW-1:0] wd_r;
			reg [BW-1:0] bw_r;
			// read return stage, one deep, overwritten every valid
			reg [DW-1:0] rdata_r;
			reg rvalid_r;

			// queue lets reads and writes arrive in any mix until its 8 entries fill
			qsp_fifo #(
				.WIDTH(QW),
				.DEPTH(`QSP_WQ_DEPTH),
				.AW(`QSP_WQ_AW)
			)
			u_wq
			(
				.clk(core_clk),
				.rst(rst_sync_r),
				.in_valid(wr_want),
				.in_ready(wq_in_ready),
				.in_data(wq_in),
				.out_valid(wq_out_valid),
				.out_ready(drain),
				.out_data(wq_out)
			);

			// command issue: one strobe per cycle on the shared bus
			always @(posedge core_clk or posedge rst_sync_r)
			begin
				if (rst_sync_r)
				begin
					rd_n_r <= 1'b1;
					wr_n_r <= 1'b1;
					addr_r <= {AW{1'b0}};
					wd_r <= {DW{1'b0}};
					bw_r <= {BW{1'b1}};
				end
				else
				begin
					// separate active-low strobes toward the sram
					rd_n_r <= ~rd_take;
					wr_n_r <= ~drain;
					// reads first, then the oldest queued write
					if (rd_take)
						addr_r <= rd_addr_v[g*AW +: AW];
					else if (drain)
						addr_r <= wq_out[QW-1 -: AW];
					// whole burst and its low-active enables
					if (drain)
					begin
						wd_r <= wq_out[BW +: DW];
						bw_r <= wq_out[BW-1:0];
					end
				end
			end

			// read return: no queue, the user must take it now
			always @(posedge core_clk or posedge rst_sync_r)
			begin
				if (rst_sync_r)
				begin
					rdata_r <= {DW{1'b0}};
					rvalid_r <= 1'b0;
				end
				else
				begin
					// memory answers in issue order, so order holds
					rvalid_r <= mem_qv_v[g] & live;
					if (mem_qv_v[g])
						rdata_r <= mem_q_v[g*DW +: DW];
				end
			end

			// hand the slices back out
			assign wr_ready_v[g] = wq_in_ready & cal_done_r & live;
			assign rd_valid_v[g] = rvalid_r;
			assign rd_data_v[g*DW +: DW] = rdata_r;
			assign mem_rd_n_v[g] = rd_n_r;
			assign mem_wr_n_v[g] = wr_n_r;
			assign mem_addr_v[g*AW +: AW] = addr_r;
			assign mem_wd_v[g*DW +: DW] = wd_r;
			assign mem_bw_v[g*BW +: BW] = bw_r;
			assign wq_level_v[g] = wq_out_valid;
		end
	endgenerate

	// user-side outputs
	assign write_ready_p0 = wr_ready_v[0];
	assign write_ready_p1 = wr_ready_v[1];
	assign read_payload_p0 = rd_data_v[DW-1:0];
	assign read_payload_p1 = rd_data_v[2*DW-1:DW];
	assign read_payload_valid_p0 = rd_valid_v[0];
	assign read_payload_valid_p1 = rd_valid_v[1];

	// memory-side outputs
	assign mem_read_n_p0 = mem_rd_n_v[0];
	assign mem_read_n_p1 = mem_rd_n_v[1];
	assign mem_write_n_p0 = mem_wr_n_v[0];
	assign mem_write_n_p1 = mem_wr_n_v[1];
	assign mem_address_p0 = mem_addr_v[AW-1:0];
	assign mem_address_p1 = mem_addr_v[2*AW-1:AW];
	assign mem_write_data_p0 = mem_wd_v[DW-1:0];
	assign mem_write_data_p1 = mem_wd_v[2*DW-1:DW];
	assign mem_byte_write_n_p0 = mem_bw_v[BW-1:0];
	assign mem_byte_write_n_p1 = mem_bw_v[2*BW-1:BW];

	// debug outputs carry internal state; nothing should load them
	assign debug_clk = core_clk;
	assign debug_bus = {burst_four_mode, burst_two_mode, wq_level_v,
		cal_state_r, cal_done_r, rst_sync_r};

endmodule

// ==== verification/qsp_user_port_assertions.sv ====
// concurrent checks on the user command port of the sram controller
`timescale 1ns/1ns
`include "qsp_defines.vh"

module qsp_user_port_assertions (
	input wire core_clk,
	input wire rst,
	input wire user_rst,
	input wire calibration_done,
	input wire write_request_p0,
	input wire [`QSP_ADDR_W-1:0] write_address_p0,
	input wire [`QSP_DATA_W-1:0] write_payload_p0,
	input wire [`QSP_BW_W-1:0] byte_write_enables_n_p0,
	input wire write_ready_p0,
	input wire read_request_p0,
	input wire [`QSP_ADDR_W-1:0] read_address_p0,
	input wire [`QSP_DATA_W-1:0] read_payload_p0,
	input wire read_payload_valid_p0,
	input wire mem_read_n_p0,
	input wire mem_write_n_p0,
	input wire [`QSP_ADDR_W-1:0] mem_address_p0,
	input wire [`QSP_DATA_W-1:0] mem_write_data_p0,
	input wire [`QSP_BW_W-1:0] mem_byte_write_n_p0,
	input wire [`QSP_DATA_W-1:0] mem_read_data_p0,
	input wire mem_read_data_valid_p0,
	input wire [`QSP_DBG_W-1:0] debug_bus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// a read taken once calibrated
	sequence s_rd0;
		calibration_done && read_request_p0;
	endsequence
	// a lone write taken while the queue is empty (bit 4 of debug)
	sequence s_wr0;
		calibration_done && write_request_p0 && write_ready_p0 &&
			!read_request_p0 && !debug_bus[4];
	endsequence
	// the queued write leaves in the next cycle if no read claims it
	sequence s_wr0_next;
		s_wr0 ##1 !read_request_p0;
	endsequence
	AST_PRECAL_IGNORED: assert property (
		!calibration_done && (read_request_p0 || write_request_p0)
		|=> mem_read_n_p0 && mem_write_n_p0)
		else $error("request issued before calibration");
	AST_RD_ISSUE: assert property (
		s_rd0 |=> !mem_read_n_p0 &&
		mem_address_p0 == $past(read_address_p0))
		else $error("read not issued with its address");
	AST_RD_FIRST: assert property (
		s_rd0 ##0 (write_request_p0 && write_ready_p0) |=> mem_write_n_p0)
		else $error("write overtook a read of the same cycle");
	AST_WR_ISSUE: assert property (
		s_wr0_next |=> !mem_write_n_p0 &&
		mem_address_p0 == $past(write_address_p0, 2) &&
		mem_write_data_p0 == $past(write_payload_p0, 2) &&
		mem_byte_write_n_p0 == $past(byte_write_enables_n_p0, 2))
		else $error("write not issued with its sidebands");
	AST_WR_ONCE: assert property (
		s_wr0_next ##0 !write_request_p0 |=>
		!mem_write_n_p0 ##1 mem_write_n_p0)
		else $error("one write gave a long strobe");
	AST_RD_VALID: assert property (
		mem_read_data_valid_p0 |=> read_payload_valid_p0 &&
		read_payload_p0 == $past(mem_read_data_p0))
		else $error("returned data not passed on");
	AST_RD_NOSPUR: assert property (
		!mem_read_data_valid_p0 |=> !read_payload_valid_p0)
		else $error("read valid without returned data");
	AST_CAL_IN_RESET: assert property (
		user_rst |-> !calibration_done)
		else $error("calibration done during user reset");
endmodule

bind qsp_user_port qsp_user_port_assertions i_chk (
	.core_clk(core_clk), .rst(rst), .user_rst(user_rst),
	.calibration_done(calibration_done),
	.write_request_p0(write_request_p0),
	.write_address_p0(write_address_p0),
	.write_payload_p0(write_payload_p0),
	.byte_write_enables_n_p0(byte_write_enables_n_p0),
	.write_ready_p0(write_ready_p0), .read_request_p0(read_request_p0),
	.read_address_p0(read_address_p0), .read_payload_p0(read_payload_p0),
	.read_payload_valid_p0(read_payload_valid_p0),
	.mem_read_n_p0(mem_read_n_p0), .mem_write_n_p0(mem_write_n_p0),
	.mem_address_p0(mem_address_p0), .mem_write_data_p0(mem_write_data_p0),
	.mem_byte_write_n_p0(mem_byte_write_n_p0),
	.mem_read_data_p0(mem_read_data_p0),
	.mem_read_data_valid_p0(mem_read_data_valid_p0),
	.debug_bus(debug_bus));

// ==== verification/qsp_sram_model.sv ====
// behavioural sram behind one memory port, fixed read latency
`timescale 1ns/1ns
`include "qsp_defines.vh"

module qsp_sram_model #(
	parameter LAT = 2
)
(
	input wire clk,
	input wire rst,
	input wire read_n,
	input wire write_n,
	input wire [`QSP_ADDR_W-1:0] addr,
	input wire [`QSP_DATA_W-1:0] wdata,
	input wire [`QSP_BW_W-1:0] bw_n,
	output wire [`QSP_DATA_W-1:0] rdata,
	output wire rvalid
);
	logic [`QSP_DATA_W-1:0] mem [int]; // sparse contents
	logic [`QSP_DATA_W-1:0] dat_r [LAT]; // read data in flight
	logic [LAT-1:0] vld_r; // read strobes in flight
	assign rvalid = vld_r[LAT-1];
	// data is not held past its valid cycle, so it toggles instead
	assign rdata = rvalid ? dat_r[LAT-1] : ~dat_r[LAT-1];
	// read looks before write, so a same-cycle pair reads old data
	always @(posedge clk or posedge rst)
	begin
		logic [`QSP_DATA_W-1:0] w;
		if (rst)
		begin
			vld_r <= '0;
			foreach (dat_r[i])
				dat_r[i] <= '0;
		end
		else
		begin
			// untouched words read as a pattern of their address
			w = mem.exists(addr) ? mem[addr] : {addr[17:0], ~addr[17:0]};
			vld_r <= {vld_r[LAT-2:0], !read_n};
			dat_r[0] <= w;
			for (int i = 1; i < LAT; i++)
				dat_r[i] <= dat_r[i-1];
			if (!write_n)
			begin
				for (int i = 0; i < `QSP_BW_W; i++)
					if (!bw_n[i])
						w[i*9 +: 9] = wdata[i*9 +: 9];
				mem[addr] = w;
			end
		end
	end
endmodule

// ==== verification/qsp_user_port_test.sv ====
// self-checking bench of the sram user command port
`timescale 1ns/1ns
`include "qsp_defines.vh"

module qsp_user_port_test;
	localparam AW = `QSP_ADDR_W;
	localparam DW = `QSP_DATA_W;
	localparam BW = `QSP_BW_W;
	logic core_clk = 1'b0; // 100 MHz system clock
	logic rst = 1'b1; // asynchronous reset, high at start
	logic [1:0] wreq = 2'h0; // write pulse per port
	logic [1:0] rreq = 2'h0; // read pulse per port
	logic [AW-1:0] wa [2]; // write address per port
	logic [AW-1:0] ra [2]; // read address per port
	logic [DW-1:0] wd [2]; // write burst per port
	logic [BW-1:0] bw [2]; // byte enables, low writes
	wire user_rst, cal_done;
	wire [1:0] wrdy, rvld, mrn, mwn, mvld;
	wire [AW-1:0] maddr [2];
	wire [DW-1:0] rpay [2], mwd [2], mrd [2];
	wire [BW-1:0] mbw [2];
	logic [DW-1:0] rq0 [$], rq1 [$]; // bursts seen with read valid
	int mismatches = 0;
	int n_compared = 0;

	always #5 core_clk = ~core_clk;

	// short calibration keeps the run brief
	qsp_user_port #(.CAL_CYCLES(16'h4)) i_dut (
		.core_clk(core_clk), .rst(rst), .user_clk(), .user_rst(user_rst),
		.calibration_done(cal_done),
		.write_request_p0(wreq[0]), .write_address_p0(wa[0]),
		.write_payload_p0(wd[0]), .byte_write_enables_n_p0(bw[0]),
		.write_ready_p0(wrdy[0]), .read_request_p0(rreq[0]),
		.read_address_p0(ra[0]), .read_payload_p0(rpay[0]),
		.read_payload_valid_p0(rvld[0]),
		.write_request_p1(wreq[1]), .write_address_p1(wa[1]),
		.write_payload_p1(wd[1]), .byte_write_enables_n_p1(bw[1]),
		.write_ready_p1(wrdy[1]), .read_request_p1(rreq[1]),
		.read_address_p1(ra[1]), .read_payload_p1(rpay[1]),
		.read_payload_valid_p1(rvld[1]),
		.mem_read_n_p0(mrn[0]), .mem_write_n_p0(mwn[0]),
		.mem_address_p0(maddr[0]), .mem_write_data_p0(mwd[0]),
		.mem_byte_write_n_p0(mbw[0]), .mem_read_data_p0(mrd[0]),
		.mem_read_data_valid_p0(mvld[0]),
		.mem_read_n_p1(mrn[1]), .mem_write_n_p1(mwn[1]),
		.mem_address_p1(maddr[1]), .mem_write_data_p1(mwd[1]),
		.mem_byte_write_n_p1(mbw[1]), .mem_read_data_p1(mrd[1]),
		.mem_read_data_valid_p1(mvld[1]),
		.debug_clk(), .debug_bus());

	// port 0 memory answers fast, port 1 slowly
	for (genvar g = 0; g < 2; g++)
	begin : g_mem
		qsp_sram_model #(.LAT(2 + 3 * g)) i_mem (.clk(core_clk), .rst(rst),
			.read_n(mrn[g]), .write_n(mwn[g]), .addr(maddr[g]),
			.wdata(mwd[g]), .bw_n(mbw[g]), .rdata(mrd[g]), .rvalid(mvld[g]));
	end

	// read data is not held, so catch it mid-cycle while valid stands
	always @(negedge core_clk)
	begin
		if (rvld[0] === 1'b1)
			rq0.push_back(rpay[0]);
		if (rvld[1] === 1'b1)
			rq1.push_back(rpay[1]);
	end

	// pattern of a word never written, and of a fill write
	function automatic logic [DW-1:0] iw(input logic [AW-1:0] a);
		return {a[17:0], ~a[17:0]};
	endfunction
	function automatic logic [DW-1:0] wv(input logic [AW-1:0] a);
		return {~a[17:0], a[17:0]};
	endfunction

	task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
	begin
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask

	task automatic final_report;
	begin
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	// drive one request cycle from a falling edge; caller ends with idle
	task automatic req(input int p, input logic w, input logic r,
		input logic [AW-1:0] a, input logic [DW-1:0] d,
		input logic [BW-1:0] b);
	begin
		wreq[p] = w;
		rreq[p] = r;
		wa[p] = a;
		ra[p] = a;
		wd[p] = d;
		bw[p] = b;
		@(negedge core_clk);
	end
	endtask

	task automatic idle(input int p);
	begin
		wreq[p] = 1'b0;
		rreq[p] = 1'b0;
		@(negedge core_clk);
	end
	endtask

	// bounded wait for the next returned burst of a port
	task automatic expect_rd(input int p, input logic [DW-1:0] exp);
	begin
		int i;
		for (i = 0; i < 30 && (p ? rq1.size() : rq0.size()) == 0; i++)
			@(negedge core_clk);
		if (i == 30)
		begin
			mismatches++;
			$display("ERROR %0t: read data never came back", $time);
			final_report();
		end
		else
			check(p ? rq1.pop_front() : rq0.pop_front(), exp);
	end
	endtask

	// requests before calibration starts must leave no trace
	task automatic t_precal;
	begin
		int i;
		req(0, 1'b1, 1'b1, 22'h5, 36'h0, 4'h0);
		check({mrn[0], mwn[0], wrdy[0]}, 3'h6);
		idle(0);
		// no request goes out before calibration is reported
		for (i = 0; i < 40 && cal_done !== 1'b1; i++)
			@(negedge core_clk);
		if (i == 40)
		begin
			mismatches++;
			$display("ERROR %0t: calibration never done", $time);
			final_report();
		end
		else
			check(cal_done, 1'b1);
		req(0, 1'b0, 1'b1, 22'h5, '0, 4'hf);
		idle(0);
		expect_rd(0, iw(22'h5));
		$display("test precal done");
	end
	endtask

	// partial byte write merges into the full one, read twice
	task automatic t_merge;
	begin
		req(0, 1'b1, 1'b0, 22'h40, 36'h123456789, 4'h0);
		idle(0);
		req(0, 1'b1, 1'b0, 22'h40, 36'hfedcba987, 4'h5);
		req(0, 1'b0, 1'b1, 22'h40, '0, 4'hf);
		idle(0);
		// the read overtakes the queued write, so old data returns
		expect_rd(0, 36'h123456789);
		req(0, 1'b0, 1'b1, 22'h40, '0, 4'hf);
		idle(0);
		expect_rd(0, (36'h123456789 & 36'h007fc01ff) |
			(36'hfedcba987 & ~36'h007fc01ff));
		$display("test merge done");
	end
	endtask

	// read and write of one address together: old data comes back
	task automatic t_same;
	begin
		req(0, 1'b1, 1'b1, 22'h77, 36'h555555555, 4'h0);
		idle(0);
		req(0, 1'b0, 1'b1, 22'h77, '0, 4'hf);
		idle(0);
		expect_rd(0, iw(22'h77));
		expect_rd(0, 36'h555555555);
		$display("test same cycle done");
	end
	endtask

	// reads every cycle return in order
	task automatic t_b2b;
	begin
		for (int i = 0; i < 4; i++)
			req(0, 1'b0, 1'b1, 22'h10 + i, '0, 4'hf);
		idle(0);
		for (int i = 0; i < 4; i++)
			expect_rd(0, iw(22'h10 + i));
		$display("test back to back done");
	end
	endtask

	// second port, slow memory, write then read back to back
	task automatic t_port1;
	begin
		req(1, 1'b1, 1'b0, 22'h3ff, 36'ha5a5a5a5a, 4'h0);
		req(1, 1'b0, 1'b1, 22'h3ff, '0, 4'hf);
		req(1, 1'b0, 1'b1, 22'h3fe, '0, 4'hf);
		idle(1);
		// both reads pass the queued write, so neither sees it
		expect_rd(1, iw(22'h3ff));
		expect_rd(1, iw(22'h3fe));
		req(1, 1'b0, 1'b1, 22'h3ff, '0, 4'hf);
		idle(1);
		expect_rd(1, 36'ha5a5a5a5a);
		$display("test port1 done");
	end
	endtask

	// reads every cycle starve writes until the queue refuses
	task automatic t_fill;
	begin
		int n;
		n = 0;
		for (int i = 0; i < 10; i++)
		begin
			if (wrdy[0] === 1'b1)
				n++;
			req(0, 1'b1, 1'b1, 22'h100 + i, wv(22'h100 + i), 4'h0);
		end
		idle(0);
		check(n, 8);
		for (int i = 0; i < 10; i++)
			expect_rd(0, iw(22'h100 + i));
		repeat (10) @(negedge core_clk);
		check(wrdy[0], 1'b1);
		req(0, 1'b0, 1'b1, 22'h107, '0, 4'hf);
		req(0, 1'b0, 1'b1, 22'h108, '0, 4'hf);
		idle(0);
		expect_rd(0, wv(22'h107));
		expect_rd(0, iw(22'h108));
		$display("test fill done");
	end
	endtask

	initial
	begin
		foreach (wa[i])
		begin
			wa[i] = '0;
			ra[i] = '0;
			wd[i] = '0;
			bw[i] = '1;
		end
		repeat (16) @(negedge core_clk);
		check({cal_done, mrn[0]}, 2'h1);
		rst = 1'b0;
		t_precal();
		t_merge();
		t_same();
		t_b2b();
		t_port1();
		t_fill();
		final_report();
	end
endmodule
